// >>> rtl/clk_cfg_pkg.sv
// Constants, types and layouts for the clock synthesizer configuration bytes
package clk_cfg_pkg;

    // ****************************************************************
    // Command and offsets
    // ****************************************************************
    localparam int CMD_BYTE_OP_BIT = 7;
    localparam logic [6:0] OFS_FREQ_SOFT_SEL = 7'h00;
    localparam logic [6:0] OFS_CURRENT_MULT = 7'h04;
    localparam logic [6:0] OFS_FREQ_STRAP = 7'h05;
    localparam logic [6:0] OFS_IDENT = 7'h06;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int SOFT_SEL_LSB = 0;
    localparam int SOFT_SEL_MSB = 4;
    localparam int MULT_SOURCE_BIT = 7;
    localparam int SOFT_MULT_HI_BIT = 6;
    localparam int SOFT_MULT_LO_BIT = 5;
    localparam int LATCHED_FS_LSB = 3;
    localparam int LATCHED_FS_MSB = 7;
    localparam int FREQ_OVERRIDE_BIT = 2;
    localparam int SHARED_RATE_BIT = 1;
    localparam int USB_RATE_BIT = 0;

    // ****************************************************************
    // Reset values and codes
    // ****************************************************************
    localparam logic [4:0] SOFT_SEL_RESET = 5'h00;
    localparam logic MULT_SOURCE_RESET = 1'b0;
    localparam logic FREQ_OVERRIDE_RESET = 1'b0;
    localparam logic SHARED_RATE_RESET = 1'b0;
    localparam logic USB_RATE_RESET = 1'b1;
    localparam logic [2:0] MULT_BASE_FACTOR = 3'h4;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ****************************************************************
    // Strap sampling timing
    // ****************************************************************
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [7:0] data;
    } byte_cmd_t;

    typedef struct packed {
        logic [4:0] freq_select;
        logic [1:0] current_mult_code;
        logic [2:0] output_high_current_factor;
        logic shared_output_rate_sel;
        logic usb_rate_output_sel;
    } clk_cfg_t;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'b01,
        ST_RUN = 2'b10
    } strap_state_t;

endpackage

// >>> rtl/clock_synth_config_bytes.sv
// Configuration bytes 0, 4, 5 and 6 of the clock synthesizer with strap capture
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps

module clock_synth_config_bytes
    import clk_cfg_pkg::*;
#(
    parameter logic [3:0] REVISION_CODE = 4'h3,  // Arbitrary value
    parameter logic [3:0] MAKER_CODE = 4'h5      // Arbitrary value
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire byte_cmd_t cmd,
    output logic cmd_ack,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic [4:0] freq_strap_inputs,
    input wire logic [1:0] current_mult_straps,
    output logic straps_captured,
    output clk_cfg_t clk_cfg
);

    // ****************************************************************
    // Strap synchronisers
    // ****************************************************************
    logic [6:0] strap_s1_reg;
    logic [6:0] strap_s2_reg;
    logic [6:0] strap_s3_reg;
    wire strap_stable = (strap_s2_reg == strap_s3_reg);

    always_ff @(posedge ref_clk) begin
        strap_s1_reg <= {current_mult_straps, freq_strap_inputs};
        strap_s2_reg <= strap_s1_reg;
        strap_s3_reg <= strap_s2_reg;
    end

    // ****************************************************************
    // One-shot strap capture after reset release
    // ****************************************************************
    strap_state_t state_reg;
    strap_state_t state_next;
    logic [1:0] settle_reg;
    logic [1:0] settle_next;
    logic capture;

    // Wait until the pipeline holds only post-reset samples, then take a stable value
    wire settled = (settle_reg == STRAP_SETTLE_CYCLES);

    always_comb begin
        state_next = state_reg;
        settle_next = settle_reg;
        capture = 1'b0;
        unique case (state_reg)
            ST_SETTLE: begin
                if (!settled) begin
                    settle_next = settle_reg + 2'h1;
                end else if (strap_stable) begin
                    capture = 1'b1;
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_reg <= ST_SETTLE;
            settle_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            settle_reg <= settle_next;
        end
    end

    assign straps_captured = (state_reg == ST_RUN);

    // ****************************************************************
    // Command decode
    // ****************************************************************
    wire byte_op = cmd.valid && cmd.code[CMD_BYTE_OP_BIT];
    wire [6:0] offset = cmd.code[6:0];
    wire wr_en = byte_op && cmd.write;
    wire rd_en = byte_op && !cmd.write;
    wire hit_soft_sel = (offset == OFS_FREQ_SOFT_SEL);
    wire hit_mult = (offset == OFS_CURRENT_MULT);
    wire hit_strap = (offset == OFS_FREQ_STRAP);
    wire hit_ident = (offset == OFS_IDENT);

    // Handshake is immediate: every byte command is taken in the cycle it is offered
    assign cmd_ack = byte_op;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [4:0] soft_sel_reg;
    logic current_mult_source_sel_reg;
    logic soft_current_mult_hi_reg;
    logic soft_current_mult_lo_reg;
    logic [4:0] latched_fs_reg;
    logic [1:0] latched_mult_reg;
    logic freq_source_override_reg;
    logic shared_output_rate_sel_reg;
    logic usb_rate_output_sel_reg;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            soft_sel_reg <= SOFT_SEL_RESET;
            current_mult_source_sel_reg <= MULT_SOURCE_RESET;
            freq_source_override_reg <= FREQ_OVERRIDE_RESET;
            shared_output_rate_sel_reg <= SHARED_RATE_RESET;
            usb_rate_output_sel_reg <= USB_RATE_RESET;
        end else if (wr_en) begin
            if (hit_soft_sel) begin
                soft_sel_reg <= cmd.data[SOFT_SEL_MSB:SOFT_SEL_LSB];
            end
            if (hit_mult) begin
                // Bit 0 is a vendor test bit the host keeps at 0; it is not stored
                current_mult_source_sel_reg <= cmd.data[MULT_SOURCE_BIT];
            end
            if (hit_strap) begin
                freq_source_override_reg <= cmd.data[FREQ_OVERRIDE_BIT];
                shared_output_rate_sel_reg <= cmd.data[SHARED_RATE_BIT];
                usb_rate_output_sel_reg <= cmd.data[USB_RATE_BIT];
            end
        end
    end

    // Capture wins over a host write of the soft multiplier in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            soft_current_mult_hi_reg <= 1'b0;
            soft_current_mult_lo_reg <= 1'b0;
        end else if (capture) begin
            soft_current_mult_hi_reg <= strap_s3_reg[6];
            soft_current_mult_lo_reg <= strap_s3_reg[5];
        end else if (wr_en && hit_mult) begin
            soft_current_mult_hi_reg <= cmd.data[SOFT_MULT_HI_BIT];
            soft_current_mult_lo_reg <= cmd.data[SOFT_MULT_LO_BIT];
        end
    end

    // Latched straps have no write path at all
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            latched_fs_reg <= 5'h00;
            latched_mult_reg <= 2'h0;
        end else if (capture) begin
            latched_fs_reg <= strap_s3_reg[4:0];
            latched_mult_reg <= strap_s3_reg[6:5];
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    wire [7:0] soft_sel_byte = {3'h0, soft_sel_reg};
    wire [7:0] mult_byte = {current_mult_source_sel_reg, soft_current_mult_hi_reg,
                            soft_current_mult_lo_reg, 5'h00};
    wire [7:0] strap_byte = {latched_fs_reg, freq_source_override_reg,
                             shared_output_rate_sel_reg, usb_rate_output_sel_reg};
    wire [7:0] ident_byte = {REVISION_CODE, MAKER_CODE};
    wire [7:0] read_mux = hit_soft_sel ? soft_sel_byte :
                          hit_mult ? mult_byte :
                          hit_strap ? strap_byte :
                          hit_ident ? ident_byte : READ_ZERO;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rd_data <= READ_ZERO;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= read_mux;
            end
        end
    end

    // ****************************************************************
    // Clock configuration outputs
    // ****************************************************************
    wire [1:0] soft_mult = {soft_current_mult_hi_reg, soft_current_mult_lo_reg};
    wire [1:0] mult_code_next = current_mult_source_sel_reg ? soft_mult
                                                            : latched_mult_reg;
    wire [2:0] factor_next = MULT_BASE_FACTOR + {1'b0, mult_code_next};
    wire [4:0] freq_next = freq_source_override_reg ? soft_sel_reg
                                                    : latched_fs_reg;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            clk_cfg <= '{freq_select: 5'h00, current_mult_code: 2'h0,
                         output_high_current_factor: MULT_BASE_FACTOR,
                         shared_output_rate_sel: SHARED_RATE_RESET,
                         usb_rate_output_sel: USB_RATE_RESET};
        end else begin
            clk_cfg.freq_select <= freq_next;
            clk_cfg.current_mult_code <= mult_code_next;
            clk_cfg.output_high_current_factor <= factor_next;
            clk_cfg.shared_output_rate_sel <= shared_output_rate_sel_reg;
            clk_cfg.usb_rate_output_sel <= usb_rate_output_sel_reg;
        end
    end

endmodule

// >>> test/clock_synth_config_bytes_asserts.sv
// Port checks for the configuration byte block
`timescale 1ns/1ps
module clock_synth_config_bytes_asserts
    import clk_cfg_pkg::*;
#(
    parameter logic [3:0] REVISION_CODE = 4'h3,  // Arbitrary value
    parameter logic [3:0] MAKER_CODE = 4'h5  // Arbitrary value
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire byte_cmd_t cmd,
    input wire logic cmd_ack,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic [4:0] freq_strap_inputs,
    input wire logic [1:0] current_mult_straps,
    input wire logic straps_captured,
    input wire clk_cfg_t clk_cfg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    wire rd_take = cmd.valid && cmd.code[7] && !cmd.write;
    wire wr_rate = cmd.valid && cmd.write && (cmd.code == 8'h85);
    // Capture must already be done, since capture beats a host write
    wire wr_mult = cmd.valid && cmd.write && (cmd.code == 8'h84) && straps_captured;
    chk_ack_follow: assert property (cmd_ack == (cmd.valid && cmd.code[7]))
        else $error("ack mismatch");
    chk_rd_pulse: assert property (rd_take |=> rd_valid)
        else $error("read pulse missing");
    chk_rd_quiet: assert property (!rd_take |=> !rd_valid)
        else $error("stray read pulse");
    chk_ident_value: assert property (rd_take && cmd.code[6:0] == OFS_IDENT
        |=> rd_data == {REVISION_CODE, MAKER_CODE}) else $error("ident wrong");
    chk_factor_sum: assert property (clk_cfg.output_high_current_factor
        == 3'h4 + {1'b0, clk_cfg.current_mult_code}) else $error("factor wrong");
    chk_usb_write: assert property (wr_rate
        |=> ##1 clk_cfg.usb_rate_output_sel == $past(cmd.data[0], 2)) else $error("usb");
    chk_shared_write: assert property (wr_rate
        |=> ##1 clk_cfg.shared_output_rate_sel == $past(cmd.data[1], 2)) else $error("shr");
    chk_mult_soft: assert property (wr_mult && cmd.data[7]
        |=> ##1 clk_cfg.current_mult_code == $past(cmd.data[6:5], 2)) else $error("mult");
    chk_capture_hold: assert property (straps_captured |=> straps_captured)
        else $error("capture dropped");
endmodule
bind clock_synth_config_bytes clock_synth_config_bytes_asserts #(
    .REVISION_CODE(REVISION_CODE), .MAKER_CODE(MAKER_CODE)) u_chk (.ref_clk(ref_clk),
    .nrst(nrst), .cmd(cmd), .cmd_ack(cmd_ack), .rd_data(rd_data), .rd_valid(rd_valid),
    .freq_strap_inputs(freq_strap_inputs), .current_mult_straps(current_mult_straps),
    .straps_captured(straps_captured), .clk_cfg(clk_cfg));

// >>> test/clock_synth_config_bytes_tb.sv
// Self-checking bench for the configuration byte block
`timescale 1ns/1ps
module clock_synth_config_bytes_tb;
    import clk_cfg_pkg::*;
    localparam logic [4:0] FS = 5'h15;
    localparam logic [1:0] MS = 2'h2;
    localparam logic [7:0] IDENT = 8'h35;  // Arbitrary value, matches the design defaults
    logic ref_clk, nrst, cmd_ack, rd_valid, straps_captured, ack, rv;
    logic [4:0] fs_pins;
    logic [1:0] ms_pins;
    logic [7:0] rd_data, rdat;
    byte_cmd_t cmd;
    clk_cfg_t cfg;
    int fails = 0;
    int total_checks = 0;
    clock_synth_config_bytes dut (.ref_clk(ref_clk), .nrst(nrst), .cmd(cmd),
        .cmd_ack(cmd_ack), .rd_data(rd_data), .rd_valid(rd_valid),
        .freq_strap_inputs(fs_pins), .current_mult_straps(ms_pins),
        .straps_captured(straps_captured), .clk_cfg(cfg));
    smbus_host_model host (.ref_clk(ref_clk), .cmd(cmd), .cmd_ack(cmd_ack),
        .rd_data(rd_data), .rd_valid(rd_valid));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] code, input logic [7:0] exp);
        host.xfer(1'b0, code, 8'h00, ack, rdat, rv);
        chk("rd ack", 8'h01, {7'h00, ack});
        chk("rd valid", 8'h01, {7'h00, rv});
        chk("rd data", exp, rdat);
    endtask
    // Output struct trails the register by one edge
    task automatic wr(input logic [7:0] code, input logic [7:0] dat);
        host.xfer(1'b1, code, dat, ack, rdat, rv);
        chk("wr ack", 8'h01, {7'h00, ack});
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic t_power_up();
        int n;
        for (n = 0; n < 20 && straps_captured !== 1'b1; n++) @(posedge ref_clk);
        #1;
        chk("captured", 8'h01, {7'h00, straps_captured});
        chk("mult", {6'h00, MS}, {6'h00, cfg.current_mult_code});
        chk("factor", 8'h06, {5'h00, cfg.output_high_current_factor});
        chk("freq", {3'h0, FS}, {3'h0, cfg.freq_select});
        chk("rates", 8'h01, {6'h00, cfg.shared_output_rate_sel, cfg.usb_rate_output_sel});
        // Pins move after capture; the latched copy must not follow them
        @(posedge ref_clk);
        fs_pins <= ~FS;
        ms_pins <= ~MS;
        repeat (4) @(posedge ref_clk);
        rd(8'h85, {FS, 3'b001});
        rd(8'h84, {1'b0, MS, 5'h00});
        rd(8'h80, 8'h00);
        $display("power up done");
    endtask
    task automatic t_ident();
        rd(8'h86, IDENT);
        wr(8'h86, 8'hCA);
        rd(8'h86, IDENT);
        rd(8'h87, 8'h00);
        host.xfer(1'b1, 8'h05, 8'hFF, ack, rdat, rv);
        chk("plain ack", 8'h00, {7'h00, ack});
        rd(8'h85, {FS, 3'b001});
        $display("ident done");
    endtask
    task automatic t_freq();
        wr(8'h85, 8'hFE);
        chk("soft freq", 8'h00, {3'h0, cfg.freq_select});
        chk("rates", 8'h02, {6'h00, cfg.shared_output_rate_sel, cfg.usb_rate_output_sel});
        rd(8'h85, {FS, 3'b110});
        wr(8'h80, 8'h0A);
        chk("sel", 8'h0A, {3'h0, cfg.freq_select});
        wr(8'h85, 8'h01);
        chk("strap freq", {3'h0, FS}, {3'h0, cfg.freq_select});
        $display("freq done");
    endtask
    task automatic t_mult();
        int i;
        for (i = 0; i < 4; i++) begin
            wr(8'h84, {1'b1, i[1:0], 5'h00});
            chk("soft mult", 8'(i), {6'h00, cfg.current_mult_code});
            chk("factor", 8'(4 + i), {5'h00, cfg.output_high_current_factor});
        end
        wr(8'h84, 8'h00);
        chk("hw mult", {6'h00, MS}, {6'h00, cfg.current_mult_code});
        $display("mult done");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        fs_pins = FS;
        ms_pins = MS;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        t_power_up();
        t_ident();
        t_freq();
        t_mult();
        stop_test();
    end
    initial begin
        #20000;
        fails++;
        stop_test();
    end
endmodule

// >>> test/smbus_host_model.sv
// Host side model issuing byte commands
`timescale 1ns/1ps
module smbus_host_model
    import clk_cfg_pkg::*;
(
    input wire logic ref_clk,
    output byte_cmd_t cmd,
    input wire logic cmd_ack,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    initial cmd = '0;
    // Released lines get the inverse so stale values never look valid
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] dat,
        output logic ack, output logic [7:0] rdat, output logic rv);
        byte_cmd_t req;
        req = '{valid: 1'b1, write: wr, code: code, data: dat};
        if (code[6:0] == OFS_CURRENT_MULT) req.data[0] = 1'b0;
        @(posedge ref_clk);
        cmd <= req;
        @(posedge ref_clk);
        ack = cmd_ack;
        cmd <= ~req;
        #1;
        rdat = rd_data;
        rv = rd_valid;
    endtask
endmodule
